// [design/asc_top.sv]
// What this block does
// - Single-mode scan end raises scan interrupt.
// - Window A/B match raises compare interrupt.
// - Group A/B/C scan ends request DMA/DATA_TRANSFER_CONTROLLER.
// - Event to link controller after all scans.
// - Link controller trigger starts a scan.
// - Group mode: non-B scan end event.
// - Group mode: group B scan end event.
// - Single mode: window condition event.
// - Module stop halts scans, compares and diagnosis capture; the register port keeps working.
// - 12-bit diag: value 11:0, status 15:14.
// - 10-bit diag: value 9:0, status 15:14.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "asc_cfg.svh"

module asc_top (
    // Clock, reset and freeze.
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic CE,
    // Module stop request from power management.
    input wire logic MSTP_REQ,
    // Register port.
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Conversion core side.
    output logic SCAN_START,
    input asc_pkg::asc_scan_evt_t SCAN_EVT,
    input asc_pkg::asc_cmp_in_t CMP_IN,
    input asc_pkg::asc_diag_t DIAG_IN,
    // Event link controller side.
    input wire logic ELC_TRIG,
    output asc_pkg::asc_elc_t ELC_OUT,
    // Interrupt, DMA and DATA_TRANSFER_CONTROLLER requests; in DMA_REQ and DTC_REQ bit 0 group A, 1 group B, 2 group C.
    output asc_pkg::asc_irq_t IRQ_OUT,
    output logic [2:0] DMA_REQ,
    output logic [2:0] DTC_REQ
);
    import asc_pkg::*;

    // ****************************************************************
    // Assertion context
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Window test: inside the closed range, or outside it when inverted.
    function automatic logic win_hit(input logic [11:0] d, input logic [31:0] w,
                                     input logic outside);
        logic in_range;
        in_range = (d >= w[11:0]) && (d <= w[`ASC_WIN_HI_LSB +: 12]);
        return in_range ^ outside;
    endfunction

    // Right-aligned diagnosis word; unused upper value bits read as zero.
    function automatic logic [15:0] fmt_diag(input logic [1:0] st, input logic [11:0] v,
                                             input logic res10);
        if (res10) begin
            return {st, 4'h0, v[9:0]};
        end
        return {st, 2'h0, v};
    endfunction

    // ****************************************************************
    // Register storage
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } asc_state_t;

    logic [`ASC_CTRL_MSB:0] ctrl_reg; // Control bits; the start bit is not stored.
    logic [31:0] wina_reg; // Window A bounds.
    logic [31:0] winb_reg; // Window B bounds.
    logic [13:0] diag_reg; // Captured diagnosis status and value.
    asc_state_t state_reg; // Scan sequencer state.
    logic half_reg; // First half of a double scan is done.
    logic stop_reg; // Module stop is in force.

    // Decoded control fields.
    asc_mode_t mode;
    logic dbl;
    assign mode = asc_mode_t'(ctrl_reg[`ASC_CTRL_MODE_HI:`ASC_CTRL_MODE_LO]);
    assign dbl = ctrl_reg[`ASC_CTRL_DBL];

    // Decoded bus strobes.
    logic wr_ctrl;
    assign wr_ctrl = WR && (ADDR == `ASC_OFS_CTRL);

    // Control register; the start bit acts on write and is not kept.
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            ctrl_reg <= `ASC_CTRL_RST;
        end else if (CE && wr_ctrl) begin
            ctrl_reg <= WDATA[`ASC_CTRL_MSB:0];
            ctrl_reg[`ASC_CTRL_START] <= 1'b0;
        end
    end

    // Window bound registers.
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            wina_reg <= {4'h0, `ASC_WIN_RST, 4'h0, `ASC_WIN_RST};
            winb_reg <= {4'h0, `ASC_WIN_RST, 4'h0, `ASC_WIN_RST};
        end else if (CE && WR) begin
            if (ADDR == `ASC_OFS_WINA) begin
                wina_reg <= WDATA & `ASC_WIN_MASK;
            end
            if (ADDR == `ASC_OFS_WINB) begin
                winb_reg <= WDATA & `ASC_WIN_MASK;
            end
        end
    end

    // Diagnosis capture; a stopped module takes no new result.
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            diag_reg <= `ASC_DIAG_RST;
        end else if (CE && !stop_reg && DIAG_IN.valid) begin
            diag_reg <= {DIAG_IN.status, DIAG_IN.value};
        end
    end

    // Module stop follows the power management request.
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            stop_reg <= 1'b0;
        end else if (CE) begin
            stop_reg <= MSTP_REQ;
        end
    end

    // ****************************************************************
    // Scan sequencer
    // ****************************************************************

    // A start comes from software or, when enabled, from the link controller.
    logic start_req;
    assign start_req = (state_reg == ST_IDLE) && !stop_reg &&
                       ((wr_ctrl && WDATA[`ASC_CTRL_START]) ||
                        (ELC_TRIG && ctrl_reg[`ASC_CTRL_TRIG_EN]));

    // Completion decode. Group A is the scan the sequencer waits for.
    logic done_a;
    logic done_b;
    logic done_c;
    logic last_a;
    assign done_a = SCAN_EVT.done && (SCAN_EVT.group == ASC_GRP_A) &&
                    (state_reg == ST_BUSY) && !stop_reg;
    assign done_b = SCAN_EVT.done && (SCAN_EVT.group == ASC_GRP_B) &&
                    (mode == ASC_MODE_GROUP) && !stop_reg;
    assign done_c = SCAN_EVT.done && (SCAN_EVT.group == ASC_GRP_C) &&
                    (mode == ASC_MODE_GROUP) && !stop_reg;
    // In double trigger mode only the second scan of the pair completes.
    assign last_a = done_a && (!dbl || half_reg);

    // Sequencer state; module stop returns it to idle.
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            state_reg <= ST_IDLE;
            half_reg <= 1'b0;
        end else if (CE) begin
            if (stop_reg) begin
                state_reg <= ST_IDLE;
                half_reg <= 1'b0;
            end else begin
                unique case (state_reg)
                    ST_IDLE: begin
                        if (start_req) begin
                            state_reg <= ST_BUSY;
                        end
                    end
                    ST_BUSY: begin
                        if (last_a) begin
                            state_reg <= ST_IDLE;
                            half_reg <= 1'b0;
                        end else if (done_a) begin
                            half_reg <= 1'b1;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Start pulse to the core, one cycle after the request is taken.
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            SCAN_START <= 1'b0;
        end else if (CE) begin
            SCAN_START <= start_req;
        end
    end

    // ****************************************************************
    // Compare windows
    // ****************************************************************
    logic hit_a;
    logic hit_b;
    logic win_evt;
    assign hit_a = CMP_IN.valid && !stop_reg &&
                   win_hit(CMP_IN.data, wina_reg, ctrl_reg[`ASC_CTRL_WINA_OUT]);
    assign hit_b = CMP_IN.valid && !stop_reg &&
                   win_hit(CMP_IN.data, winb_reg, ctrl_reg[`ASC_CTRL_WINB_OUT]);
    // Link event combines both windows by OR, or by AND when selected.
    assign win_evt = (mode == ASC_MODE_SINGLE) &&
                     (ctrl_reg[`ASC_CTRL_WIN_AND] ? (hit_a && hit_b) : (hit_a || hit_b));

    // ****************************************************************
    // Request and event pulses
    // ****************************************************************

    // Interrupt pulses; each lasts one enabled cycle.
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            IRQ_OUT <= '0;
        end else if (CE) begin
            IRQ_OUT.scan_end <= last_a && ctrl_reg[`ASC_CTRL_SCAN_IE];
            IRQ_OUT.group_b <= done_b && ctrl_reg[`ASC_CTRL_SCAN_IE];
            IRQ_OUT.group_c <= done_c && ctrl_reg[`ASC_CTRL_SCAN_IE];
            IRQ_OUT.window_a <= hit_a && ctrl_reg[`ASC_CTRL_CMP_IE];
            IRQ_OUT.window_b <= hit_b && ctrl_reg[`ASC_CTRL_CMP_IE];
        end
    end

    // DMA and DATA_TRANSFER_CONTROLLER activation from the three scan end sources.
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            DMA_REQ <= 3'h0;
            DTC_REQ <= 3'h0;
        end else if (CE) begin
            DMA_REQ <= {done_c, done_b, last_a} & {3{ctrl_reg[`ASC_CTRL_DMA_EN]}};
            DTC_REQ <= {done_c, done_b, last_a} & {3{ctrl_reg[`ASC_CTRL_DTC_EN]}};
        end
    end

    // Event link pulses.
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            ELC_OUT <= '0;
        end else if (CE) begin
            ELC_OUT.all_done <= last_a;
            ELC_OUT.non_b_done <= (last_a && (mode == ASC_MODE_GROUP)) || done_c;
            ELC_OUT.group_b_done <= done_b;
            ELC_OUT.window <= win_evt;
        end
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************

    // Read data stand in the cycle after the strobe only; unmapped reads zero.
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            RDATA <= 32'h00000000;
        end else if (CE) begin
            RDATA <= 32'h00000000;
            if (RD) begin
                unique case (ADDR)
                    `ASC_OFS_CTRL: RDATA <= {19'h00000, ctrl_reg};
                    `ASC_OFS_WINA: RDATA <= wina_reg;
                    `ASC_OFS_WINB: RDATA <= winb_reg;
                    `ASC_OFS_STAT: RDATA <= {29'h00000000, stop_reg, half_reg,
                                             state_reg == ST_BUSY};
                    `ASC_OFS_DIAG: RDATA <= {16'h0000, fmt_diag(diag_reg[13:12],
                                             diag_reg[11:0], ctrl_reg[`ASC_CTRL_RES10])};
                    default: RDATA <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    trig_starts_a: assert property (CE && ELC_TRIG && ctrl_reg[`ASC_CTRL_TRIG_EN] &&
        state_reg == ST_IDLE && !stop_reg |=> state_reg == ST_BUSY)
        else $error("Link trigger did not start a scan.");
    scan_irq_a: assert property (CE && last_a && ctrl_reg[`ASC_CTRL_SCAN_IE] &&
        mode == ASC_MODE_SINGLE |=> IRQ_OUT.scan_end && ELC_OUT.all_done)
        else $error("Scan end did not raise its interrupt.");
    cmp_irq_a: assert property (CE && CMP_IN.valid && !stop_reg && ctrl_reg[`ASC_CTRL_CMP_IE] &&
        win_hit(CMP_IN.data, wina_reg, ctrl_reg[`ASC_CTRL_WINA_OUT]) |=> IRQ_OUT.window_a)
        else $error("Window A match gave no interrupt.");
    dma_req_a: assert property (CE && ctrl_reg[`ASC_CTRL_DMA_EN] && done_b |=> DMA_REQ[1])
        else $error("Group B end gave no DMA request.");
    all_done_a: assert property (CE && $rose(ELC_OUT.all_done) |-> $past(state_reg) == ST_BUSY)
        else $error("All-done event without a running scan.");
    grp_b_elc_a: assert property (CE && done_b |=> ELC_OUT.group_b_done && !ELC_OUT.all_done)
        else $error("Group B end event wrong.");
    non_b_elc_a: assert property (CE && done_c |=> ELC_OUT.non_b_done)
        else $error("Group C end gave no non-B event.");
    win_elc_a: assert property (CE && mode != ASC_MODE_SINGLE |=> !ELC_OUT.window)
        else $error("Window event outside single mode.");
    stop_idle_a: assert property (CE && stop_reg |=> state_reg == ST_IDLE && !SCAN_START)
        else $error("Stopped module kept scanning.");
    diag_fmt_a: assert property (RD && ADDR == `ASC_OFS_DIAG && ctrl_reg[`ASC_CTRL_RES10] &&
        CE |=> RDATA[13:10] == 4'h0 && RDATA[15:14] == $past(diag_reg[13:12]))
        else $error("Ten-bit diagnosis word malformed.");
    diag12_a: assert property (RD && ADDR == `ASC_OFS_DIAG && !ctrl_reg[`ASC_CTRL_RES10] &&
        CE |=> RDATA[13:12] == 2'h0 && RDATA[11:0] == $past(diag_reg[11:0]))
        else $error("Twelve-bit diagnosis word malformed.");
    pulse_one_a: assert property (CE && IRQ_OUT.scan_end && CE ##0 1'b1 |=>
        (!CE || !IRQ_OUT.scan_end || $past(last_a)))
        else $error("Scan interrupt stretched without cause.");

    // Main scenarios.
    single_scan_c: cover property (start_req ##[1:50] last_a);
    group_b_c: cover property (done_b && mode == ASC_MODE_GROUP);
    double_c: cover property (done_a && !last_a ##[1:50] last_a);
    window_c: cover property (win_evt && ctrl_reg[`ASC_CTRL_WIN_AND]);

endmodule

// [inc/asc_cfg.svh]
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// Register byte offsets on the plain register port.
`define ASC_OFS_CTRL 8'h00
`define ASC_OFS_WINA 8'h04
`define ASC_OFS_WINB 8'h08
`define ASC_OFS_STAT 8'h0C
`define ASC_OFS_DIAG 8'h10

// Control register field positions.
`define ASC_CTRL_START 0
`define ASC_CTRL_MODE_LO 1
`define ASC_CTRL_MODE_HI 2
`define ASC_CTRL_DBL 3
`define ASC_CTRL_RES10 4
`define ASC_CTRL_SCAN_IE 5
`define ASC_CTRL_CMP_IE 6
`define ASC_CTRL_TRIG_EN 7
`define ASC_CTRL_WIN_AND 8
`define ASC_CTRL_WINA_OUT 9
`define ASC_CTRL_WINB_OUT 10
`define ASC_CTRL_DMA_EN 11
`define ASC_CTRL_DTC_EN 12
`define ASC_CTRL_MSB 12
`define ASC_CTRL_RST 13'h0000

// Window register layout: low bound in the low half, high bound in the high half.
`define ASC_WIN_HI_LSB 16
`define ASC_WIN_RST 12'h000
// Only the two 12-bit bounds are kept; every other window bit reads zero.
`define ASC_WIN_MASK 32'h0FFF0FFF

// Self-diagnosis word layout.
`define ASC_DIAG_STAT_LSB 14
`define ASC_DIAG_RST 14'h0000

`endif

// [inc/asc_pkg.sv]
package asc_pkg;

    // Scan modes selected through the control register.
    typedef enum logic [1:0] {
        ASC_MODE_SINGLE = 2'h0,
        ASC_MODE_GROUP = 2'h1,
        ASC_MODE_CONT = 2'h2,
        ASC_MODE_RSVD = 2'h3
    } asc_mode_t;

    // Group codes reported by the conversion core.
    typedef enum logic [1:0] {
        ASC_GRP_A = 2'h0,
        ASC_GRP_B = 2'h1,
        ASC_GRP_C = 2'h2,
        ASC_GRP_X = 2'h3
    } asc_grp_t;

    // Scan completion report from the core.
    typedef struct packed {
        logic done;
        asc_grp_t group;
    } asc_scan_evt_t;

    // One converted result offered to the compare windows.
    typedef struct packed {
        logic valid;
        logic [11:0] data;
    } asc_cmp_in_t;

    // Self-diagnosis result from the core.
    typedef struct packed {
        logic valid;
        logic [1:0] status;
        logic [11:0] value;
    } asc_diag_t;

    // Interrupt request pulses.
    typedef struct packed {
        logic scan_end;
        logic group_b;
        logic group_c;
        logic window_a;
        logic window_b;
    } asc_irq_t;

    // Event link pulses.
    typedef struct packed {
        logic all_done;
        logic non_b_done;
        logic group_b_done;
        logic window;
    } asc_elc_t;

endpackage

// [dv/asc_elc_model.sv]
`timescale 1ns/1ns

// ************************************************************
// Event link controller model.
// ************************************************************
module asc_elc_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Bench request to route one start trigger.
    input wire logic fire,
    // Start trigger towards the converter.
    output logic trig,
    // Events from the converter and their running count.
    input asc_pkg::asc_elc_t evt,
    output int evt_count
);
    import asc_pkg::*;

    // The trigger leaves one edge after the request, as routing through a link costs a cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig <= 1'b0;
        end else begin
            trig <= fire;
        end
    end

    // Every event bit is counted, so lost or doubled events show in the total.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evt_count <= 0;
        end else begin
            evt_count <= evt_count + $countones(evt);
        end
    end
endmodule

// [dv/tb.sv]
`timescale 1ns/1ns
`include "asc_cfg.svh"

module tb;
    import asc_pkg::*;

    // ************************************************************
    // Signals and bookkeeping.
    // ************************************************************
    localparam logic [15:0] EV_START = 16'h8000; // Scan start pulse alone.
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic mstp_req = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic fire = 1'b0;
    logic ce = 1'b1;
    asc_scan_evt_t scan_evt = '0;
    asc_cmp_in_t cmp_in = '0;
    asc_diag_t diag_in = '0;
    logic [31:0] rdata;
    logic scan_start;
    logic elc_trig;
    asc_elc_t elc_out;
    asc_irq_t irq_out;
    logic [2:0] dma_req;
    logic [2:0] dtc_req;
    int elc_count;
    logic [15:0] ev_q[$]; // Expected pulse words, oldest first.
    logic [31:0] rd_q[$]; // Expected read data, oldest first.
    logic rd_pend = 1'b0; // Read data are due in this cycle.
    int failures = 0;
    int comparisons = 0;
    int elc_exp = 0;
    int cycles = 0;
    wire logic [15:0] ev_word = {scan_start, irq_out, elc_out, dma_req, dtc_req};

    // The clock enable is driven low once, around a write, to show the freeze.
    asc_top i_dut (
        .SYS_CLK(sys_clk), .RESET(reset), .CE(ce), .MSTP_REQ(mstp_req),
        .ADDR(addr), .WDATA(wdata), .WR(wr_stb), .RD(rd_stb), .RDATA(rdata),
        .SCAN_START(scan_start), .SCAN_EVT(scan_evt), .CMP_IN(cmp_in), .DIAG_IN(diag_in),
        .ELC_TRIG(elc_trig), .ELC_OUT(elc_out), .IRQ_OUT(irq_out),
        .DMA_REQ(dma_req), .DTC_REQ(dtc_req)
    );

    asc_elc_model i_elc (
        .clk(sys_clk), .rst(reset), .fire(fire), .trig(elc_trig),
        .evt(elc_out), .evt_count(elc_count)
    );

    // Free running clock, 8 ns period.
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // Compare, report and timeout.
    // ************************************************************
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // The run needs well under a thousand cycles; a hang is cut at five thousand.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end

    // Outputs are looked at mid-cycle, once every edge's updates have landed.
    always @(posedge sys_clk) rd_pend <= rd_stb;
    always @(negedge sys_clk) begin
        if (!reset && rd_pend) begin
            cmp32(rdata, (rd_q.size() > 0) ? rd_q.pop_front() : 32'hDEAD_0000);
        end
        // Any pulse with no note waiting is an extra or stretched pulse.
        if (!reset && ev_word !== 16'h0000) begin
            cmp16(ev_word, (ev_q.size() > 0) ? ev_q.pop_front() : 16'h0000);
        end
    end

    // ************************************************************
    // Drivers.
    // ************************************************************
    task automatic note(input logic [15:0] w);
        ev_q.push_back(w);
        elc_exp += $countones(w[9:6]);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
    endtask

    task automatic scan_done(input asc_grp_t g);
        @(posedge sys_clk);
        scan_evt <= '{done: 1'b1, group: g};
        @(posedge sys_clk);
        scan_evt.done <= 1'b0;
    endtask

    task automatic elc_fire;
        @(posedge sys_clk);
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
    endtask

    task automatic diag_drive(input logic [1:0] st, input logic [11:0] v);
        @(posedge sys_clk);
        diag_in <= '{valid: 1'b1, status: st, value: v};
        @(posedge sys_clk);
        diag_in.valid <= 1'b0;
    endtask

    // Window A spans 100..200 and window B 800..FFF; single mode is assumed.
    task automatic cmp_drive(input logic [31:0] c, input logic [11:0] d);
        logic ha;
        logic hb;
        logic [15:0] w;
        ha = ((d >= 12'h100) && (d <= 12'h200)) ^ c[9];
        hb = (d >= 12'h800) ^ c[10];
        w = {1'b0, 3'h0, ha & c[6], hb & c[6], 3'h0, c[8] ? (ha & hb) : (ha | hb), 6'h00};
        if (w !== 16'h0000) note(w);
        @(posedge sys_clk);
        cmp_in <= '{valid: 1'b1, data: d};
        @(posedge sys_clk);
        cmp_in.valid <= 1'b0;
    endtask

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        logic [31:0] cfg [3];
        logic [11:0] edge_v [4];
        logic [11:0] d;
        cfg = '{32'h0000_0040, 32'h0000_0140, 32'h0000_0640};
        edge_v = '{12'h100, 12'h200, 12'h201, 12'h7FF};
        void'($urandom(32'hA23D));
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        // Reset values, forced bits and an unmapped place.
        reg_rd(`ASC_OFS_CTRL, 32'h0);
        reg_rd(`ASC_OFS_STAT, 32'h0);
        reg_wr(`ASC_OFS_WINA, 32'hFFFF_FFFF);
        reg_rd(`ASC_OFS_WINA, 32'h0FFF_0FFF);
        reg_wr(8'h40, 32'hFFFF_FFFF);
        reg_rd(8'h40, 32'h0);
        reg_wr(`ASC_OFS_WINA, 32'h0200_0100);
        reg_wr(`ASC_OFS_WINB, 32'h0FFF_0800);
        // Link trigger starts a scan; a second trigger while busy is ignored.
        reg_wr(`ASC_OFS_CTRL, 32'h0000_18A0);
        note(EV_START);
        elc_fire();
        reg_rd(`ASC_OFS_STAT, 32'h1);
        elc_fire();
        note({1'b0, 5'h10, 4'h8, 3'h1, 3'h1});
        scan_done(ASC_GRP_A);
        reg_rd(`ASC_OFS_STAT, 32'h0);
        // Group mode: B and C end back to back, then A ends the sequence.
        note(EV_START);
        reg_wr(`ASC_OFS_CTRL, 32'h0000_1823);
        reg_rd(`ASC_OFS_CTRL, 32'h0000_1822);
        note({1'b0, 5'h08, 4'h2, 3'h2, 3'h2});
        note({1'b0, 5'h04, 4'h4, 3'h4, 3'h4});
        @(posedge sys_clk);
        scan_evt <= '{done: 1'b1, group: ASC_GRP_B};
        @(posedge sys_clk);
        scan_evt <= '{done: 1'b1, group: ASC_GRP_C};
        @(posedge sys_clk);
        scan_evt.done <= 1'b0;
        note({1'b0, 5'h10, 4'hC, 3'h1, 3'h1});
        scan_done(ASC_GRP_A);
        // Double trigger: the first half is silent, DMA and DATA_TRANSFER_CONTROLLER stay off.
        note(EV_START);
        reg_wr(`ASC_OFS_CTRL, 32'h0000_0029);
        scan_done(ASC_GRP_A);
        reg_rd(`ASC_OFS_STAT, 32'h3);
        note({1'b0, 5'h10, 4'h8, 3'h0, 3'h0});
        scan_done(ASC_GRP_A);
        reg_rd(`ASC_OFS_STAT, 32'h0);
        // Windows in OR, AND and outside forms, bounds and random data.
        for (int k = 0; k < 3; k++) begin
            reg_wr(`ASC_OFS_CTRL, cfg[k]);
            for (int i = 0; i < 8; i++) begin
                d = (i < 4) ? edge_v[i] : 12'($urandom);
                cmp_drive(cfg[k], d);
            end
        end
        // Diagnosis word in both right-aligned resolutions.
        reg_wr(`ASC_OFS_CTRL, 32'h0);
        diag_drive(2'h2, 12'hABC);
        reg_rd(`ASC_OFS_DIAG, 32'h0000_8ABC);
        reg_wr(`ASC_OFS_CTRL, 32'h0000_0010);
        reg_rd(`ASC_OFS_DIAG, 32'h0000_82BC);
        diag_drive(2'h3, 12'hFFF);
        reg_rd(`ASC_OFS_DIAG, 32'h0000_C3FF);
        reg_wr(`ASC_OFS_CTRL, 32'h0);
        reg_rd(`ASC_OFS_DIAG, 32'h0000_CFFF);
        // Clock enable low: a start write is neither stored nor taken.
        @(posedge sys_clk);
        ce <= 1'b0;
        reg_wr(`ASC_OFS_CTRL, 32'h0000_0011);
        ce <= 1'b1;
        reg_rd(`ASC_OFS_STAT, 32'h0);
        reg_rd(`ASC_OFS_CTRL, 32'h0);
        // Module stop: no capture, no start from either source.
        @(posedge sys_clk);
        mstp_req <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reg_rd(`ASC_OFS_STAT, 32'h4);
        diag_drive(2'h1, 12'h123);
        reg_wr(`ASC_OFS_CTRL, 32'h0000_0081);
        elc_fire();
        reg_rd(`ASC_OFS_DIAG, 32'h0000_CFFF);
        @(posedge sys_clk);
        mstp_req <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reg_rd(`ASC_OFS_STAT, 32'h0);
        repeat (4) @(posedge sys_clk);
        cmp32(32'(ev_q.size() + rd_q.size()), 32'h0);
        cmp32(32'(elc_count), 32'(elc_exp));
        results();
    end
endmodule
